// >>> timer_consts.vh
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH
// Register byte addresses
`define TMR_A_CTRL_ADDR 12'h000
`define TMR_A_PER_ADDR 12'h004
`define TMR_A_PW_ADDR 12'h008
`define TMR_B_CTRL_ADDR 12'h00C
`define TMR_B_PER_ADDR 12'h010
`define TMR_B_PW_ADDR 12'h014
`define TMR_STATUS_ADDR 12'h018
// Control register fields
`define CTL_FF_BIT 7
`define CTL_CK_HI 6
`define CTL_CK_LO 4
`define CTL_RUN_BIT 3
`define CTL_MODE_HI 2
`define CTL_MODE_LO 0
// Reset values
`define CTRL_RESET 8'h00
`define PER_RESET 8'hFF
`define PW_RESET 8'hFF
// Clock select codes
`define CK_DIV11 3'h0
`define CK_DIV7 3'h1
`define CK_DIV5 3'h2
`define CK_DIV3 3'h3
`define CK_RSVD 3'h4
`define CK_DIV1 3'h5
`define CK_FULL 3'h6
`define CK_EXT 3'h7
// Mode codes
`define MODE_DIVOUT8 3'h1
`define MODE_PWM8 3'h2
`define MODE_CASCADE 3'h3
`define MODE_PWM16 3'h6
`endif

// >>> timer_tick_sel.v
`timescale 1ns/1ps
`default_nettype none
`include "timer_consts.vh"
module timer_tick_sel
(
    input wire [11:0] prescale,
    input wire [11:0] prescale_prev,
    input wire ext_rise,
    input wire [2:0] sel,
    output reg tick
);
    // Rising edge of a prescaler bit gives one tick per divided period
    function edge_of;
        input [11:0] now;
        input [11:0] prev;
        input integer bitn;
        begin
            edge_of = now[bitn] & ~prev[bitn];
        end
    endfunction

    always @*
    begin
        case (sel)
            `CK_DIV11: tick = edge_of(prescale, prescale_prev, 10);
            `CK_DIV7: tick = edge_of(prescale, prescale_prev, 6);
            `CK_DIV5: tick = edge_of(prescale, prescale_prev, 4);
            `CK_DIV3: tick = edge_of(prescale, prescale_prev, 2);
            `CK_DIV1: tick = edge_of(prescale, prescale_prev, 0);
            `CK_FULL: tick = 1'b1;
            `CK_EXT: tick = ext_rise;
            default: tick = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// >>> dual_timer_ctrl.v
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "timer_consts.vh"
module dual_timer_ctrl
(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire a_count_pin,
    input wire b_count_pin,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg [7:0] a_count,
    output reg [7:0] b_count,
    output reg a_ff_out,
    output reg b_ff_out
);
    reg [7:0] a_ctrl_q;
    reg [7:0] b_ctrl_q;
    reg [7:0] a_per_q;
    reg [7:0] a_pw_q;
    reg [7:0] b_per_q;
    reg [7:0] b_pw_q;
    reg [11:0] pre_q;
    reg [11:0] pre_prev_q;
    reg [1:0] a_pin_q;
    reg [1:0] b_pin_q;
    reg [7:0] a_cnt_q;
    reg [7:0] b_cnt_q;
    reg a_ff_q;
    reg b_ff_q;
    reg [7:0] ctl_d;
    wire a_tick;
    wire b_tick;
    wire a_run;
    wire b_run;
    wire cascade;
    wire run16;
    wire a_cnt_go;
    wire b_cnt_go;
    wire a_wrap;
    wire b_wrap;
    wire acc;
    wire wr;
    wire a_pwm_ok;
    wire b_pwm_ok;

    function is_pwm;
        input [2:0] m;
        begin
            is_pwm = (m == `MODE_PWM8) || (m == `MODE_PWM16);
        end
    endfunction

    // New config accepted only while stopped; a write to a running timer can only clear its run bit
    function [7:0] ctl_merge;
        input [7:0] old;
        input [7:0] wv;
        begin
            if (old[`CTL_RUN_BIT] && !wv[`CTL_RUN_BIT])
                ctl_merge = old & ~(8'h01 << `CTL_RUN_BIT);
            else if (old[`CTL_RUN_BIT])
                ctl_merge = old;
            else
                ctl_merge = wv;
        end
    endfunction

    assign acc = psel & penable & pready;
    assign wr = acc & pwrite;
    assign a_run = a_ctrl_q[`CTL_RUN_BIT];
    assign b_run = b_ctrl_q[`CTL_RUN_BIT];
    assign cascade = (a_ctrl_q[`CTL_MODE_HI:`CTL_MODE_LO] == `MODE_CASCADE);
    assign run16 = cascade & b_run;
    assign a_pwm_ok = cascade ? (b_ctrl_q[`CTL_MODE_HI:`CTL_MODE_LO] == `MODE_PWM16) :
        (a_ctrl_q[`CTL_MODE_HI:`CTL_MODE_LO] == `MODE_PWM8);
    assign b_pwm_ok = is_pwm(b_ctrl_q[`CTL_MODE_HI:`CTL_MODE_LO]);

    ////////////////////////////////////////////////////////////////////////
    // Clock selection

    timer_tick_sel u_a_sel
    (
        .prescale(pre_q),
        .prescale_prev(pre_prev_q),
        .ext_rise(a_pin_q[0] & ~a_pin_q[1]),
        .sel(a_ctrl_q[`CTL_CK_HI:`CTL_CK_LO]),
        .tick(a_tick)
    );

    timer_tick_sel u_b_sel
    (
        .prescale(pre_q),
        .prescale_prev(pre_prev_q),
        .ext_rise(b_pin_q[0] & ~b_pin_q[1]),
        .sel(b_ctrl_q[`CTL_CK_HI:`CTL_CK_LO]),
        .tick(b_tick)
    );

    assign a_cnt_go = cascade ? (run16 & a_tick) : (a_run & a_tick);
    assign a_wrap = (a_cnt_q == a_per_q);
    // Upper byte counts on lower byte wrap in cascade
    assign b_cnt_go = cascade ? (a_cnt_go & (a_cnt_q == 8'hFF)) : (b_run & b_tick);
    assign b_wrap = (b_cnt_q == b_per_q);

    ////////////////////////////////////////////////////////////////////////
    // Prescaler and pin sampling

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pre_q <= 12'h000;
            pre_prev_q <= 12'h000;
            a_pin_q <= 2'h0;
            b_pin_q <= 2'h0;
        end
        else
        begin
            pre_q <= pre_q + 12'h001;
            pre_prev_q <= pre_q;
            a_pin_q <= {a_pin_q[0], a_count_pin};
            b_pin_q <= {b_pin_q[0], b_count_pin};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file

    always @*
    begin
        ctl_d = 8'h00;
        if (paddr == `TMR_A_CTRL_ADDR)
            ctl_d = ctl_merge(a_ctrl_q, pwdata[7:0]);
        else if (paddr == `TMR_B_CTRL_ADDR)
            ctl_d = ctl_merge(b_ctrl_q, pwdata[7:0]);
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            a_ctrl_q <= `CTRL_RESET;
            b_ctrl_q <= `CTRL_RESET;
            a_per_q <= `PER_RESET;
            a_pw_q <= `PW_RESET;
            b_per_q <= `PER_RESET;
            b_pw_q <= `PW_RESET;
        end
        else if (wr)
        begin
            if (paddr == `TMR_A_CTRL_ADDR)
                a_ctrl_q <= ctl_d;
            else if (paddr == `TMR_A_PER_ADDR)
            begin
                if (!a_run && !run16)
                    a_per_q <= pwdata[7:0];
            end
            else if (paddr == `TMR_A_PW_ADDR)
            begin
                if ((!a_run && !run16) || a_pwm_ok)
                    a_pw_q <= pwdata[7:0];
            end
            else if (paddr == `TMR_B_CTRL_ADDR)
                b_ctrl_q <= ctl_d;
            else if (paddr == `TMR_B_PER_ADDR)
            begin
                if (!b_run)
                    b_per_q <= pwdata[7:0];
            end
            else if (paddr == `TMR_B_PW_ADDR)
            begin
                if (!b_run || b_pwm_ok)
                    b_pw_q <= pwdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB answer, one wait-free access phase

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (psel && !penable)
            begin
                if (paddr == `TMR_A_CTRL_ADDR)
                    prdata <= {24'h000000, a_ctrl_q};
                else if (paddr == `TMR_A_PER_ADDR)
                    prdata <= {24'h000000, a_per_q};
                else if (paddr == `TMR_A_PW_ADDR)
                    prdata <= {24'h000000, a_pw_q};
                else if (paddr == `TMR_B_CTRL_ADDR)
                    prdata <= {24'h000000, b_ctrl_q};
                else if (paddr == `TMR_B_PER_ADDR)
                    prdata <= {24'h000000, b_per_q};
                else if (paddr == `TMR_B_PW_ADDR)
                    prdata <= {24'h000000, b_pw_q};
                else if (paddr == `TMR_STATUS_ADDR)
                    prdata <= {12'h000, b_ff_q, a_ff_q, 2'h0, b_cnt_q, a_cnt_q};
                else
                    pslverr <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counters and flip-flops

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            a_cnt_q <= 8'h00;
            b_cnt_q <= 8'h00;
            a_ff_q <= 1'b0;
            b_ff_q <= 1'b0;
        end
        else
        begin
            if (cascade ? !run16 : !a_run)
            begin
                a_cnt_q <= 8'h00;
                a_ff_q <= cascade ? b_ctrl_q[`CTL_FF_BIT] : a_ctrl_q[`CTL_FF_BIT];
            end
            else if (a_cnt_go)
            begin
                if (!cascade && a_wrap)
                begin
                    a_cnt_q <= 8'h00;
                    a_ff_q <= ~a_ff_q;
                end
                else
                    a_cnt_q <= a_cnt_q + 8'h01;
            end
            if (!b_run)
            begin
                b_cnt_q <= 8'h00;
                b_ff_q <= b_ctrl_q[`CTL_FF_BIT];
            end
            else if (b_cnt_go)
            begin
                if (b_wrap)
                begin
                    b_cnt_q <= 8'h00;
                    b_ff_q <= ~b_ff_q;
                    if (cascade)
                        a_cnt_q <= 8'h00;
                end
                else
                    b_cnt_q <= b_cnt_q + 8'h01;
            end
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            a_count <= 8'h00;
            b_count <= 8'h00;
            a_ff_out <= 1'b0;
            b_ff_out <= 1'b0;
        end
        else
        begin
            a_count <= a_cnt_q;
            b_count <= b_cnt_q;
            a_ff_out <= a_ff_q;
            b_ff_out <= cascade ? a_ff_q : b_ff_q;
        end
    end
endmodule
`default_nettype wire

// >>> dual_timer_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_consts.vh"
module dual_timer_chk
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] a_count,
    input wire logic [7:0] b_count
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence b_stop_s;
        pready && pwrite && paddr == `TMR_B_CTRL_ADDR && !pwdata[`CTL_RUN_BIT];
    endsequence
    a_ready_next: assert property (setup_s |=> pready)
        else $error("no ready after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held");
    a_ready_cause: assert property (pready |-> $past(psel) && !$past(penable))
        else $error("ready without setup");
    a_unmapped_err: assert property (pready && paddr[1:0] == 2'b00 |->
        pslverr == (paddr > `TMR_STATUS_ADDR)) else $error("error flag wrong");
    a_upper_zero: assert property (pready && !pwrite && !pslverr |->
        prdata[31:20] == 12'h000) else $error("upper read bits set");
    a_stop_clears: assert property (b_stop_s |-> ##3 (b_count == 8'h00) [*2])
        else $error("stop kept count");
    a_step_a: assert property (a_count != $past(a_count) |->
        a_count == $past(a_count) + 8'h01 || a_count == 8'h00) else $error("a count jump");
    a_step_b: assert property (b_count != $past(b_count) |->
        b_count == $past(b_count) + 8'h01 || b_count == 8'h00) else $error("b count jump");
endmodule
bind dual_timer_ctrl dual_timer_chk dual_timer_chk_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .a_count, .b_count);
`default_nettype wire

// >>> dual_timer_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_consts.vh"
module dual_timer_ctrl_tb;
    localparam logic [11:0] ac = `TMR_A_CTRL_ADDR;
    localparam logic [11:0] ap = `TMR_A_PER_ADDR;
    localparam logic [11:0] aw = `TMR_A_PW_ADDR;
    localparam logic [11:0] bc = `TMR_B_CTRL_ADDR;
    localparam logic [11:0] bp = `TMR_B_PER_ADDR;
    localparam logic [11:0] bw = `TMR_B_PW_ADDR;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic a_count_pin = 1'b0;
    logic b_count_pin = 1'b0;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire [7:0] a_count;
    wire [7:0] b_count;
    wire a_ff_out;
    wire b_ff_out;
    logic [33:0] exp_q[$];
    logic [33:0] e;
    logic [7:0] pv;
    logic [7:0] pw;
    int err_count = 0;
    int samples_checked = 0;

    dual_timer_ctrl dual_timer_ctrl_inst
    (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .a_count_pin,
        .b_count_pin, .prdata, .pready, .pslverr, .a_count, .b_count, .a_ff_out, .b_ff_out
    );

    initial forever #2.5 pclk = ~pclk;

    always @(posedge pclk)
    begin
        a_count_pin <= ~a_count_pin;
        b_count_pin <= 1'($urandom);
    end
    ////////////////////////////////////////
    task bad(input string m);
        err_count++;
        $display("BAD %0t %s", $time, m);
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [33:0] x);
        @(posedge pclk);
        exp_q.push_back(x);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [7:0] d);
        apb(1'b0, a, d, {2'b10, 24'h000000, d});
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 34'h000000000);
    endtask
    task chk(input logic c, input string m);
        samples_checked++;
        if (c !== 1'b1)
            bad(m);
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Answers are compared in arrival order
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1)
        begin
            e = exp_q.pop_front();
            samples_checked++;
            if (pslverr !== e[32] || (e[33] && prdata !== e[31:0]))
                bad("register answer");
        end
    end

    initial
    begin
        #100000;
        err_count++;
        close_out();
    end
    ////////////////////////////////////////
    initial
    begin
        pv = 8'($urandom(32'h537C));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(ac, `CTRL_RESET);
        rd(ap, `PER_RESET);
        rd(aw, `PW_RESET);
        rd(bc, `CTRL_RESET);
        rd(bp, `PER_RESET);
        rd(bw, `PW_RESET);
        apb(1'b0, 12'h01C, 8'h00, {2'b01, 32'h00000000});
        // Top bit keeps the running count of timer b short of its period
        pv = 8'($urandom) | 8'h80;
        pw = 8'($urandom);
        wr(bp, pv);
        rd(bp, pv);
        wr(aw, pw);
        rd(aw, pw);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            wr(ac, {1'b0, 3'(i), 1'b1, `MODE_PWM8});
            rd(ac, {1'b0, 3'(i), 1'b1, `MODE_PWM8});
            repeat (40) @(posedge pclk);
            if (i == 4)
                chk(a_count === 8'h00, "reserved clock counted");
            else if (i >= 3)
                chk(a_count !== 8'h00, "no counting");
            wr(ac, {1'b0, 3'(i), 1'b0, `MODE_PWM8});
            repeat (3) @(posedge pclk);
            chk(a_count === 8'h00, "stop kept count");
        end
        $display("test clocks done");
        wr(ac, {1'b1, `CK_FULL, 1'b1, `MODE_DIVOUT8});
        wr(ac, {1'b0, `CK_DIV1, 1'b1, `MODE_PWM8});
        rd(ac, {1'b1, `CK_FULL, 1'b1, `MODE_DIVOUT8});
        wr(ap, 8'h10);
        rd(ap, `PER_RESET);
        wr(aw, 8'h33);
        rd(aw, pw);
        wr(ac, {1'b0, `CK_DIV11, 1'b0, `MODE_PWM8});
        rd(ac, {1'b1, `CK_FULL, 1'b0, `MODE_DIVOUT8});
        chk(a_ff_out === 1'b1 && a_count === 8'h00, "stop state");
        wr(ac, {1'b0, `CK_FULL, 1'b1, `MODE_PWM8});
        wr(aw, 8'h5A);
        rd(aw, 8'h5A);
        wr(ac, {1'b0, `CK_FULL, 1'b0, `MODE_PWM8});
        $display("test timer a done");
        wr(bc, {1'b0, `CK_FULL, 1'b1, `MODE_DIVOUT8});
        wr(bp, 8'h22);
        rd(bp, pv);
        wr(bw, 8'h44);
        rd(bw, `PW_RESET);
        chk(b_count !== 8'h00, "b idle");
        wr(bc, {1'b0, `CK_FULL, 1'b0, `MODE_DIVOUT8});
        wr(bc, {1'b0, `CK_FULL, 1'b1, `MODE_PWM16});
        wr(bw, 8'hA5);
        rd(bw, 8'hA5);
        wr(bc, {1'b0, `CK_FULL, 1'b0, `MODE_PWM16});
        // Timer b left in a pulse width mode must not open timer a's width
        wr(ac, {1'b0, `CK_FULL, 1'b1, `MODE_DIVOUT8});
        wr(aw, 8'h66);
        rd(aw, 8'h5A);
        wr(ac, {1'b0, `CK_FULL, 1'b0, `MODE_DIVOUT8});
        rd(`TMR_STATUS_ADDR, 8'h00);
        $display("test timer b done");
        wr(ac, {1'b0, `CK_FULL, 1'b0, `MODE_CASCADE});
        wr(bc, {1'b1, `CK_DIV11, 1'b1, 3'h4});
        repeat (20) @(posedge pclk);
        chk(a_count !== 8'h00, "cascade idle");
        wr(ap, 8'h10);
        rd(ap, `PER_RESET);
        wr(bc, {1'b1, `CK_DIV11, 1'b0, 3'h4});
        repeat (3) @(posedge pclk);
        chk(b_count === 8'h00 && a_count === 8'h00 && b_ff_out === 1'b1, "cascade stop");
        $display("test cascade done");
        close_out();
    end
endmodule
`default_nettype wire
